// ===== core/sfbu_core.sv
// Shift, flag and branch execution unit with an AHB-Lite register slave
//
// How it works
// RULE1: Left shift loads carry from old bit 7
// RULE2: Shifts set overflow to negative xor carry
// RULE3: Byte shifts: N from bit 7, Z all-zero
// RULE4: Double shift: pair left, zero in, old 15 to carry
// RULE5: Double shift: N from bit 15, Z sixteen-bit
// RULE6: Right shift keeps bit 7, bit 0 to carry
// RULE7: Taken branch: PC plus two plus signed offset
// RULE8: Never-branch only advances PC by two
// RULE9: Carry branches test carry clear or set
// RULE10: Equal branches test zero flag
// RULE11: Sign branches test negative flag
// RULE12: Overflow branches test overflow flag
// RULE13: Signed ge when N equals V
// RULE14: Signed gt when Z clear and N equals V
// RULE15: Unsigned higher when C and Z clear
// RULE16: Signed le when Z set or N differs V
// RULE17: Unsigned lower-same when C or Z set
// RULE18: Signed lt when N differs from V
// RULE19: Always-branch loads target unconditionally
// RULE20: Call: PC+2, push low, dec, push high, dec, add offset
// RULE21: Bit test ANDs, sets N Z, clears V, keeps C
// RULE22: Left shift inserts zero at bit 0
// RULE23: Offset sign-extended, target wraps modulo 65536
module sfbu_core (
    input  wire logic        hclk,        // Bus and core clock
    input  wire logic        hresetn,     // Asynchronous reset, active low
    input  wire logic        hsel,        // Slave select
    input  wire logic [31:0] haddr,       // Byte address
    input  wire logic [1:0]  htrans,      // Transfer type
    input  wire logic        hwrite,      // Write when high
    input  wire logic [2:0]  hsize,       // Transfer size
    input  wire logic [31:0] hwdata,      // Write data
    input  wire logic        hready,      // Bus ready
    output logic             hreadyout,   // Slave ready
    output logic             hresp,       // Always OKAY
    output logic [31:0]      hrdata,      // Read data
    output logic             push_valid,  // One-cycle stack write strobe
    output logic [15:0]      push_addr,   // Stack write address
    output logic [7:0]       push_data    // Stack write byte
);

    // Bus phase tracking
    sfbu_pkg::sfbu_ap_t    ap_q, ap_d;     // Captured address phase
    logic                  rdy_q, rdy_d;   // Ready flop
    logic [31:0]           rdata_q;        // Read data flop

    // Architectural state
    logic [7:0]            acc_a_q, acc_a_d;
    logic [7:0]            acc_b_q, acc_b_d;
    logic [7:0]            mem_q, mem_d;
    sfbu_pkg::sfbu_ccr_t   ccr_q, ccr_d;
    logic [15:0]           pc_q, pc_d;
    logic [15:0]           sp_q, sp_d;
    logic [7:0]            rel_q, rel_d;
    logic [15:0]           pushed_q, pushed_d;   // {high byte, low byte} of last call
    logic                  taken_q, taken_d;     // Last branch outcome
    sfbu_pkg::sfbu_state_t st_q, st_d;
    logic                  pv_q;                 // Push strobe flop
    logic [15:0]           pa_q;                 // Push address flop
    logic [7:0]            pd_q;                 // Push data flop

    // Bus decode
    wire        addr_ph  = hsel & hready & htrans[1];
    wire        idle     = (st_q == sfbu_pkg::ST_IDLE);
    wire        wr_en    = ap_q.valid & ap_q.write;
    wire        wr_free  = wr_en & idle;   // Writes during a call are dropped
    wire        wr_cmd   = wr_free & (ap_q.addr == sfbu_pkg::OFF_CMD);
    wire        wr_acc_a = wr_free & (ap_q.addr == sfbu_pkg::OFF_ACC_A);
    wire        wr_acc_b = wr_free & (ap_q.addr == sfbu_pkg::OFF_ACC_B);
    wire        wr_mem   = wr_free & (ap_q.addr == sfbu_pkg::OFF_MEM);
    wire        wr_ccr   = wr_free & (ap_q.addr == sfbu_pkg::OFF_CCR);
    wire        wr_pc    = wr_free & (ap_q.addr == sfbu_pkg::OFF_PC);
    wire        wr_sp    = wr_free & (ap_q.addr == sfbu_pkg::OFF_SP);
    wire        wr_rel   = wr_free & (ap_q.addr == sfbu_pkg::OFF_REL);

    // Command fields straight from the write data
    wire [4:0]  cmd_op   = hwdata[sfbu_pkg::CMD_OP_LSB +: 5];
    wire [1:0]  cmd_tgt  = hwdata[sfbu_pkg::CMD_TGT_LSB +: 2];
    wire        go_shl   = wr_cmd & (cmd_op == sfbu_pkg::OP_SHL);
    wire        go_shr   = wr_cmd & (cmd_op == sfbu_pkg::OP_SHR);
    wire        go_dshl  = wr_cmd & (cmd_op == sfbu_pkg::OP_DSHL);
    wire        go_bit   = wr_cmd & (cmd_op == sfbu_pkg::OP_BIT);
    wire        go_call  = wr_cmd & (cmd_op == sfbu_pkg::OP_CALL);
    wire        go_br    = wr_cmd & cmd_op[4];
    wire        go_sh8   = go_shl | go_shr;
    wire        go_flags = go_sh8 | go_dshl | go_bit;

    // Operand selection
    wire [7:0]  src8  = (cmd_tgt == sfbu_pkg::TGT_B) ? acc_b_q :
                        (cmd_tgt == sfbu_pkg::TGT_M) ? mem_q : acc_a_q;
    wire [7:0]  tst_acc = (cmd_tgt == sfbu_pkg::TGT_B) ? acc_b_q : acc_a_q;
    wire [15:0] pair  = {acc_a_q, acc_b_q};

    // Shift and test results
    wire [7:0]  shl_r  = {src8[6:0], 1'b0};              // [RULE22]
    wire [7:0]  shr_r  = {src8[7], src8[7:1]};           // [RULE6]
    wire [15:0] dshl_r = {pair[14:0], 1'b0};             // [RULE4]
    wire [7:0]  bit_r  = tst_acc & mem_q;                // [RULE21]
    wire [7:0]  sh8_r  = go_shr ? shr_r : shl_r;
    wire [7:0]  res8   = go_bit ? bit_r : sh8_r;

    // New flag values
    wire        n_new = go_dshl ? dshl_r[15] : res8[7];                 // [RULE3] [RULE5]
    wire        z_new = go_dshl ? (dshl_r == 16'h0000) : (res8 == 8'h00); // [RULE3] [RULE5]
    wire        c_new = go_dshl ? pair[15] :                            // [RULE4]
                        go_shl  ? src8[7] :                             // [RULE1]
                        go_shr  ? src8[0] : ccr_q.c;                    // [RULE6] [RULE21]
    wire        v_new = go_bit ? 1'b0 : (n_new ^ c_new);                // [RULE2] [RULE21]

    // Branch target, offset sign-extended, sum wraps in sixteen bits
    wire [15:0] rel16  = {{8{rel_q[7]}}, rel_q};           // [RULE23]
    wire [15:0] pc_nx  = pc_q + sfbu_pkg::PC_STEP;         // [RULE8]
    wire [15:0] target = pc_nx + rel16;                    // [RULE7] [RULE23]

    // Branch condition per test code
    wire        f_n = ccr_q.n;
    wire        f_z = ccr_q.z;
    wire        f_v = ccr_q.v;
    wire        f_c = ccr_q.c;
    wire [15:0] cond_vec;
    assign cond_vec[sfbu_pkg::BR_ALWAYS] = 1'b1;                    // [RULE19]
    assign cond_vec[sfbu_pkg::BR_NEVER]  = 1'b0;                    // [RULE8]
    assign cond_vec[sfbu_pkg::BR_HI]     = ~(f_c | f_z);            // [RULE15]
    assign cond_vec[sfbu_pkg::BR_LS]     = f_c | f_z;               // [RULE17]
    assign cond_vec[sfbu_pkg::BR_CC]     = ~f_c;                    // [RULE9]
    assign cond_vec[sfbu_pkg::BR_CS]     = f_c;                     // [RULE9]
    assign cond_vec[sfbu_pkg::BR_NE]     = ~f_z;                    // [RULE10]
    assign cond_vec[sfbu_pkg::BR_EQ]     = f_z;                     // [RULE10]
    assign cond_vec[sfbu_pkg::BR_VC]     = ~f_v;                    // [RULE12]
    assign cond_vec[sfbu_pkg::BR_VS]     = f_v;                     // [RULE12]
    assign cond_vec[sfbu_pkg::BR_PL]     = ~f_n;                    // [RULE11]
    assign cond_vec[sfbu_pkg::BR_MI]     = f_n;                     // [RULE11]
    assign cond_vec[sfbu_pkg::BR_GE]     = ~(f_n ^ f_v);            // [RULE13]
    assign cond_vec[sfbu_pkg::BR_LT]     = f_n ^ f_v;               // [RULE18]
    assign cond_vec[sfbu_pkg::BR_GT]     = ~f_z & ~(f_n ^ f_v);     // [RULE14]
    assign cond_vec[sfbu_pkg::BR_LE]     = f_z | (f_n ^ f_v);       // [RULE16]
    wire        taken = cond_vec[cmd_op[3:0]];

    // Register next values; software writes and operations never coincide
    assign acc_a_d = wr_acc_a ? hwdata[7:0] :
                     (go_sh8 & (cmd_tgt == sfbu_pkg::TGT_A)) ? sh8_r :
                     go_dshl ? dshl_r[15:8] : acc_a_q;                   // [RULE4]
    assign acc_b_d = wr_acc_b ? hwdata[7:0] :
                     (go_sh8 & (cmd_tgt == sfbu_pkg::TGT_B)) ? sh8_r :
                     go_dshl ? dshl_r[7:0] : acc_b_q;
    assign mem_d   = wr_mem ? hwdata[7:0] :
                     (go_sh8 & (cmd_tgt == sfbu_pkg::TGT_M)) ? sh8_r : mem_q;
    // Half-carry and interrupt mask pass through untouched
    assign ccr_d   = wr_ccr ? sfbu_pkg::sfbu_ccr_t'(hwdata[5:0]) :
                     go_flags ? {ccr_q.h, ccr_q.i, n_new, z_new, v_new, c_new} : ccr_q; // [RULE3]
    assign pc_d    = wr_pc ? hwdata[15:0] :
                     go_br ? (taken ? target : pc_nx) :                  // [RULE7] [RULE8]
                     go_call ? pc_nx :                                   // [RULE20]
                     (st_q == sfbu_pkg::ST_REL) ? pc_q + rel16 : pc_q;   // [RULE20]
    assign sp_d    = wr_sp ? hwdata[15:0] :
                     ((st_q == sfbu_pkg::ST_PUSH_LO) | (st_q == sfbu_pkg::ST_PUSH_HI)) ?
                     sp_q - sfbu_pkg::SP_STEP : sp_q;                    // [RULE20]
    assign rel_d   = wr_rel ? hwdata[7:0] : rel_q;
    assign pushed_d = (st_q == sfbu_pkg::ST_PUSH_LO) ? {pushed_q[15:8], pc_q[7:0]} :
                      (st_q == sfbu_pkg::ST_PUSH_HI) ? {pc_q[15:8], pushed_q[7:0]} : pushed_q;
    assign taken_d = go_br ? taken : taken_q;

    // Call sequencer: one state per step, low byte first
    always_comb begin
        case (st_q)
            sfbu_pkg::ST_IDLE:    st_d = go_call ? sfbu_pkg::ST_PUSH_LO : sfbu_pkg::ST_IDLE; // [RULE20]
            sfbu_pkg::ST_PUSH_LO: st_d = sfbu_pkg::ST_PUSH_HI;
            sfbu_pkg::ST_PUSH_HI: st_d = sfbu_pkg::ST_REL;
            sfbu_pkg::ST_REL:     st_d = sfbu_pkg::ST_IDLE;
            default:              st_d = sfbu_pkg::ST_IDLE;
        endcase
    end

    // Bus phase: reads take one wait state so a write just before is seen
    assign ap_d  = addr_ph ? {1'b1, hwrite & (hsize == sfbu_pkg::HSIZE_WRD), haddr[7:0]}
                           : '0;
    assign rdy_d = ~(addr_ph & ~hwrite);

    // Read multiplexer, unmapped reads return zero
    wire [31:0] rd_mux =
        (ap_q.addr == sfbu_pkg::OFF_CMD)   ? 32'h0000_0000 :
        (ap_q.addr == sfbu_pkg::OFF_ACC_A) ? {24'h00_0000, acc_a_q} :
        (ap_q.addr == sfbu_pkg::OFF_ACC_B) ? {24'h00_0000, acc_b_q} :
        (ap_q.addr == sfbu_pkg::OFF_MEM)   ? {24'h00_0000, mem_q} :
        (ap_q.addr == sfbu_pkg::OFF_CCR)   ? {26'h000_0000, ccr_q} :
        (ap_q.addr == sfbu_pkg::OFF_PC)    ? {16'h0000, pc_q} :
        (ap_q.addr == sfbu_pkg::OFF_SP)    ? {16'h0000, sp_q} :
        (ap_q.addr == sfbu_pkg::OFF_REL)   ? {24'h00_0000, rel_q} :
        (ap_q.addr == sfbu_pkg::OFF_PUSH)  ? {16'h0000, pushed_q} :
        (ap_q.addr == sfbu_pkg::OFF_STAT)  ? {30'h0000_0000, taken_q, ~idle} : 32'h0000_0000;
    wire        rd_stall = ap_q.valid & ~rdy_q;

    // Bus flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q    <= '0;
            rdy_q   <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            ap_q    <= rd_stall ? ap_q : ap_d;
            rdy_q   <= rd_stall ? 1'b1 : rdy_d;
            rdata_q <= rd_stall ? rd_mux : rdata_q;
        end
    end

    // Architectural flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_a_q  <= 8'h00;
            acc_b_q  <= 8'h00;
            mem_q    <= 8'h00;
            ccr_q    <= sfbu_pkg::RST_CCR;
            pc_q     <= sfbu_pkg::RST_PC;
            sp_q     <= sfbu_pkg::RST_SP;
            rel_q    <= 8'h00;
            pushed_q <= 16'h0000;
            taken_q  <= 1'b0;
            st_q     <= sfbu_pkg::ST_IDLE;
        end else begin
            acc_a_q  <= acc_a_d;
            acc_b_q  <= acc_b_d;
            mem_q    <= mem_d;
            ccr_q    <= ccr_d;
            pc_q     <= pc_d;
            sp_q     <= sp_d;
            rel_q    <= rel_d;
            pushed_q <= pushed_d;
            taken_q  <= taken_d;
            st_q     <= st_d;
        end
    end

    // Stack write port, pushes at the current pointer before it drops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pv_q <= 1'b0;
            pa_q <= 16'h0000;
            pd_q <= 8'h00;
        end else begin
            pv_q <= (st_q == sfbu_pkg::ST_PUSH_LO) | (st_q == sfbu_pkg::ST_PUSH_HI); // [RULE20]
            pa_q <= sp_q;
            pd_q <= (st_q == sfbu_pkg::ST_PUSH_LO) ? pc_q[7:0] : pc_q[15:8];
        end
    end

    assign hreadyout  = rdy_q;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_q;
    assign push_valid = pv_q;
    assign push_addr  = pa_q;
    assign push_data  = pd_q;

    // Checks
    property p_shl_carry;
        @(posedge hclk) disable iff (!hresetn)
        go_shl & (cmd_tgt == sfbu_pkg::TGT_A) |=> ccr_q.c == $past(acc_a_q[7]) && acc_a_q[0] == 1'b0;
    endproperty
    a_shl_carry: assert property (p_shl_carry) else $error("left shift carry wrong"); // [RULE1]

    property p_shift_v;
        @(posedge hclk) disable iff (!hresetn)
        go_sh8 | go_dshl |=> ccr_q.v == (ccr_q.n ^ ccr_q.c);
    endproperty
    a_shift_v: assert property (p_shift_v) else $error("shift overflow wrong"); // [RULE2]

    property p_sh8_nz;
        @(posedge hclk) disable iff (!hresetn)
        go_sh8 & (cmd_tgt == sfbu_pkg::TGT_M) |=> ccr_q.n == mem_q[7] && ccr_q.z == (mem_q == 8'h00)
            && ccr_q.h == $past(ccr_q.h) && ccr_q.i == $past(ccr_q.i);
    endproperty
    a_sh8_nz: assert property (p_sh8_nz) else $error("byte shift flags wrong"); // [RULE3]

    property p_dshl;
        @(posedge hclk) disable iff (!hresetn)
        go_dshl |=> {acc_a_q, acc_b_q} == {$past(acc_a_q[6:0]), $past(acc_b_q), 1'b0}
            && ccr_q.c == $past(acc_a_q[7]);
    endproperty
    a_dshl: assert property (p_dshl) else $error("double shift wrong"); // [RULE4]

    property p_dshl_nz;
        @(posedge hclk) disable iff (!hresetn)
        go_dshl |=> ccr_q.n == acc_a_q[7] && ccr_q.z == ({acc_a_q, acc_b_q} == 16'h0000);
    endproperty
    a_dshl_nz: assert property (p_dshl_nz) else $error("double shift flags wrong"); // [RULE5]

    property p_shr;
        @(posedge hclk) disable iff (!hresetn)
        go_shr & (cmd_tgt == sfbu_pkg::TGT_B) |=> acc_b_q == {$past(acc_b_q[7]), $past(acc_b_q[7:1])}
            && ccr_q.c == $past(acc_b_q[0]);
    endproperty
    a_shr: assert property (p_shr) else $error("right shift wrong"); // [RULE6]

    property p_br_taken;
        @(posedge hclk) disable iff (!hresetn)
        go_br & taken |=> pc_q == $past(pc_q) + 16'h0002 + {{8{rel_q[7]}}, rel_q};
    endproperty
    a_br_taken: assert property (p_br_taken) else $error("branch target wrong"); // [RULE7]

    property p_br_never;
        @(posedge hclk) disable iff (!hresetn)
        go_br & (cmd_op[3:0] == sfbu_pkg::BR_NEVER) |=> pc_q == $past(pc_q) + 16'h0002 && taken_q == 1'b0;
    endproperty
    a_br_never: assert property (p_br_never) else $error("never-branch moved wrongly"); // [RULE8]

    property p_call;
        @(posedge hclk) disable iff (!hresetn)
        go_call |-> ##1 push_valid == 1'b0 ##1 push_valid ##1 push_valid ##1
            (sp_q == $past(sp_q, 4) - 16'h0002) && (pc_q == $past(pc_q, 4) + 16'h0002 + rel16) && idle;
    endproperty
    a_call: assert property (p_call) else $error("call sequence wrong"); // [RULE20]

    property p_bit;
        @(posedge hclk) disable iff (!hresetn)
        go_bit |=> acc_a_q == $past(acc_a_q) && mem_q == $past(mem_q) && !ccr_q.v && ccr_q.c == $past(ccr_q.c);
    endproperty
    a_bit: assert property (p_bit) else $error("bit test wrong"); // [RULE21]

    // Signed decision uses the flags as they stood at the command
    property p_br_ge;
        @(posedge hclk) disable iff (!hresetn)
        go_br & (cmd_op[3:0] == sfbu_pkg::BR_GE) |=> taken_q == ~($past(ccr_q.n) ^ $past(ccr_q.v));
    endproperty
    a_br_ge: assert property (p_br_ge) else $error("signed ge decision wrong"); // [RULE13]

    // Always-branch never falls through, whatever the flags
    property p_br_always;
        @(posedge hclk) disable iff (!hresetn)
        go_br & (cmd_op[3:0] == sfbu_pkg::BR_ALWAYS) |=> taken_q;
    endproperty
    a_br_always: assert property (p_br_always) else $error("always-branch not taken"); // [RULE19]

    // Reads cost exactly one wait state, so software sees fresh state
    property p_rd_wait;
        @(posedge hclk) disable iff (!hresetn)
        hsel & hready & htrans[1] & ~hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

    c_dshl:  cover property (@(posedge hclk) disable iff (!hresetn) go_dshl);
    c_taken: cover property (@(posedge hclk) disable iff (!hresetn) go_br & taken);
    c_call:  cover property (@(posedge hclk) disable iff (!hresetn) go_call ##4 idle);
    c_wrap:  cover property (@(posedge hclk) disable iff (!hresetn) go_br & taken & (target < pc_nx) & ~rel_q[7]);

endmodule // sfbu_core

// ===== core/sfbu_pkg.sv
// Shared constants and types for the shift, flag and branch unit
package sfbu_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_CMD   = 8'h00; // Command, write starts an operation
    localparam logic [7:0] OFF_ACC_A = 8'h04; // Accumulator A
    localparam logic [7:0] OFF_ACC_B = 8'h08; // Accumulator B
    localparam logic [7:0] OFF_MEM   = 8'h0c; // Memory operand byte
    localparam logic [7:0] OFF_CCR   = 8'h10; // Condition codes
    localparam logic [7:0] OFF_PC    = 8'h14; // Program counter
    localparam logic [7:0] OFF_SP    = 8'h18; // Stack pointer
    localparam logic [7:0] OFF_REL   = 8'h1c; // Relative offset byte
    localparam logic [7:0] OFF_PUSH  = 8'h20; // Last pushed bytes, read only
    localparam logic [7:0] OFF_STAT  = 8'h24; // Busy and last taken, read only

    // Values after reset
    localparam logic [15:0] RST_PC  = 16'h0000;
    localparam logic [15:0] RST_SP  = 16'h00ff;
    localparam logic [5:0]  RST_CCR = 6'h10;    // Interrupt mask set

    // Command field positions
    localparam int unsigned CMD_OP_LSB  = 0;
    localparam int unsigned CMD_TGT_LSB = 8;

    // Operation codes
    localparam logic [4:0] OP_SHL  = 5'h01; // shift_left_arith
    localparam logic [4:0] OP_DSHL = 5'h02; // double_shift_left
    localparam logic [4:0] OP_SHR  = 5'h03; // shift_right_arith
    localparam logic [4:0] OP_BIT  = 5'h04; // Bit test
    localparam logic [4:0] OP_CALL = 5'h05; // relative_subroutine_call
    localparam logic [4:0] OP_BR   = 5'h10; // Base of the sixteen branch tests

    // Branch test codes, low nibble of a branch operation
    localparam logic [3:0] BR_ALWAYS = 4'h0;
    localparam logic [3:0] BR_NEVER  = 4'h1;
    localparam logic [3:0] BR_HI     = 4'h2;
    localparam logic [3:0] BR_LS     = 4'h3;
    localparam logic [3:0] BR_CC     = 4'h4;
    localparam logic [3:0] BR_CS     = 4'h5;
    localparam logic [3:0] BR_NE     = 4'h6;
    localparam logic [3:0] BR_EQ     = 4'h7;
    localparam logic [3:0] BR_VC     = 4'h8;
    localparam logic [3:0] BR_VS     = 4'h9;
    localparam logic [3:0] BR_PL     = 4'ha;
    localparam logic [3:0] BR_MI     = 4'hb;
    localparam logic [3:0] BR_GE     = 4'hc;
    localparam logic [3:0] BR_LT     = 4'hd;
    localparam logic [3:0] BR_GT     = 4'he;
    localparam logic [3:0] BR_LE     = 4'hf;

    // Shift target select
    localparam logic [1:0] TGT_A = 2'h0;
    localparam logic [1:0] TGT_B = 2'h1;
    localparam logic [1:0] TGT_M = 2'h2;

    // Steps and bus constants
    localparam logic [15:0] PC_STEP   = 16'h0002;
    localparam logic [15:0] SP_STEP   = 16'h0001;
    localparam logic [2:0]  HSIZE_WRD = 3'h2;

    // Condition code layout, bit 5 down to bit 0
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic v;
        logic c;
    } sfbu_ccr_t;

    // Captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } sfbu_ap_t;

    // Sequencer states for the subroutine call
    typedef enum logic [1:0] {ST_IDLE, ST_PUSH_LO, ST_PUSH_HI, ST_REL} sfbu_state_t;

endpackage

// ===== dv/sfbu_bench.sv
// Self-checking bench: random operands, every operation, model compare
module sfbu_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, push_valid;
    logic [31:0] haddr, hwdata, hrdata, rdv, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] push_addr, mpc, msp;
    logic [7:0]  push_data, ma, mb, mm, mrel;
    logic [5:0]  mcc;                // Model flags H I N Z V C
    logic [23:0] pq[$], ep[$];       // Seen and expected stack writes
    int          failures, compares;

    sfbu_core u_sfbu_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .push_valid(push_valid), .push_addr(push_addr), .push_data(push_data));

    // Free-running 125 MHz clock
    initial hclk = 1'b0;
    always #4 hclk = ~hclk;

    // Record every stack write strobe
    always @(posedge hclk) begin
        if (hresetn === 1'b1 && push_valid === 1'b1) pq.push_back({push_addr, push_data});
    end

    // Xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Branch decision from model flags, nibble order of the command encoding
    function automatic logic taken(input logic [3:0] k);
        logic n, z, v, c;
        {n, z, v, c} = mcc[3:0];
        case (k)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return !(c | z);
            4'h3: return c | z;
            4'h4: return !c;
            4'h5: return c;
            4'h6: return !z;
            4'h7: return z;
            4'h8: return !v;
            4'h9: return v;
            4'ha: return !n;
            4'hb: return n;
            4'hc: return !(n ^ v);
            4'hd: return n ^ v;
            4'he: return !z && !(n ^ v);
            default: return z || (n ^ v);
        endcase
    endfunction

    // Single place where the run ends
    task automatic finish_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Wait for hready sampled high; value seen just before that edge
    task automatic wait_rdy(output logic [31:0] q);
        logic r;
        r = 1'b0;
        for (int n = 0; n < 16 && r !== 1'b1; n++) begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
        end
        if (r !== 1'b1) begin
            failures++;
            $display("BAD t=%0t bus hang", $time);
            finish_test();
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsize  <= sfbu_pkg::HSIZE_WRD;
        wait_rdy(rdv);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(rdv);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(rdv, exp, what);
        chk({31'h0, hresp}, 32'h0, "resp");
    endtask

    initial begin
        logic [4:0]  op;
        logic [1:0]  t;
        logic [7:0]  x, r;
        logic [15:0] dd;
        logic        tk;
        int          j;
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        seed = 32'hd380;
        failures = 0;
        compares = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(sfbu_pkg::OFF_CCR, {26'h0, sfbu_pkg::RST_CCR}, "reset ccr");
        rd(sfbu_pkg::OFF_SP, {16'h0, sfbu_pkg::RST_SP}, "reset sp");
        for (int it = 0; it < 208; it++) begin
            j = it % 26;
            {ma, mb, mm, mrel} = rnd();
            {mpc, msp} = rnd();
            mcc = 6'(rnd());
            xfer(1'b1, sfbu_pkg::OFF_ACC_A, {24'h0, ma});
            xfer(1'b1, sfbu_pkg::OFF_ACC_B, {24'h0, mb});
            xfer(1'b1, sfbu_pkg::OFF_MEM, {24'h0, mm});
            xfer(1'b1, sfbu_pkg::OFF_CCR, {26'h0, mcc});
            xfer(1'b1, sfbu_pkg::OFF_PC, {16'h0, mpc});
            xfer(1'b1, sfbu_pkg::OFF_SP, {16'h0, msp});
            xfer(1'b1, sfbu_pkg::OFF_REL, {24'h0, mrel});
            // Table index to operation and target
            t = 2'(j < 3 ? j : (j > 3 && j < 7) ? j - 4 : (j == 7 || j == 8) ? j - 7 : 0);
            op = 5'(j < 3 ? 1 : j == 3 ? 2 : j < 7 ? 3 : j < 9 ? 4 : j == 9 ? 5 : 6 + j);
            x = t == 2'h1 ? mb : t == 2'h2 ? mm : ma;
            tk = 1'b0;
            case (op)
                5'h01: {mcc[0], r} = {x, 1'b0};
                5'h03: {r, mcc[0]} = {x[7], x};
                5'h02: begin
                    {mcc[0], dd} = {ma, mb, 1'b0};
                    {ma, mb} = dd;
                    mcc[3:2] = {dd[15], dd == 16'h0};
                end
                5'h04: begin
                    r = (t == 2'h1 ? mb : ma) & mm;
                    mcc[3:1] = {r[7], r == 8'h0, 1'b0};
                end
                5'h05: begin
                    mpc += 16'h2;
                    ep.push_back({msp, mpc[7:0]});
                    msp -= 16'h1;
                    ep.push_back({msp, mpc[15:8]});
                    msp -= 16'h1;
                    mpc += {{8{mrel[7]}}, mrel};
                end
                default: begin
                    tk = taken(op[3:0]);
                    mpc = mpc + 16'h2 + (tk ? {{8{mrel[7]}}, mrel} : 16'h0);
                end
            endcase
            if (op == 5'h01 || op == 5'h03) begin
                mcc[3:2] = {r[7], r == 8'h0};
                if (t == 2'h0) ma = r;
                else if (t == 2'h1) mb = r;
                else mm = r;
            end
            if (op < 5'h04) mcc[1] = mcc[3] ^ mcc[0];
            xfer(1'b1, sfbu_pkg::OFF_CMD, {22'h0, t, 3'h0, op});
            // A call stays busy for a few cycles; poll with a bound
            for (int n = 0; n < 8 && op == 5'h05; n++) begin
                xfer(1'b0, sfbu_pkg::OFF_STAT, 32'h0);
                if (rdv[0] === 1'b0) break;
            end
            if (op == 5'h05 && rdv[0] !== 1'b0) begin
                failures++;
                $display("BAD t=%0t call stays busy", $time);
                finish_test();
            end
            rd(sfbu_pkg::OFF_ACC_A, {24'h0, ma}, "acc a");
            rd(sfbu_pkg::OFF_ACC_B, {24'h0, mb}, "acc b");
            rd(sfbu_pkg::OFF_MEM, {24'h0, mm}, "mem");
            rd(sfbu_pkg::OFF_CCR, {26'h0, mcc}, "ccr");
            rd(sfbu_pkg::OFF_PC, {16'h0, mpc}, "pc");
            rd(sfbu_pkg::OFF_SP, {16'h0, msp}, "sp");
            if (op >= 5'h10) rd(sfbu_pkg::OFF_STAT, {30'h0, tk, 1'b0}, "taken");
            if (op == 5'h05) rd(sfbu_pkg::OFF_PUSH, {16'h0, ep[1][7:0], ep[0][7:0]}, "pushed");
            chk(32'(pq.size()), 32'(ep.size()), "push count");
            while (ep.size() > 0 && pq.size() > 0) chk({8'h0, pq.pop_front()}, {8'h0, ep.pop_front()}, "push");
            pq.delete();
            ep.delete();
        end
        rd(8'h3c, 32'h0, "unmapped");
        finish_test();
    end
endmodule // sfbu_bench
